// [include/fbcd_cfg.svh]
// Constants of the four-bit core datapath
`ifndef FBCD_CFG_SVH
`define FBCD_CFG_SVH
`define FBCD_PAGE_W 7
`define FBCD_STEP_W 6
`define FBCD_ROM_W 8
`define FBCD_ADDR_W 8
`define FBCD_NIB_W 4
`define FBCD_SEG_N 64
`define FBCD_DISP_BASE 8'hc0
`define FBCD_DISP_TOP_NIB 2'h3
`define FBCD_PHASE_N 4
`define FBCD_PHASE_DIV 16'd1000
`define FBCD_ZERO_NIB 4'h0
`endif

// [include/fbcd_pkg.sv]
// Types of the four-bit core datapath
package fbcd_pkg;
    typedef enum logic [3:0] {
        FBCD_ALU_ADD = 4'h1,
        FBCD_ALU_ADC = 4'h2,
        FBCD_ALU_AND = 4'h3,
        FBCD_ALU_OR = 4'h4,
        FBCD_ALU_XOR = 4'h5,
        FBCD_ALU_CPL = 4'h6,
        FBCD_ALU_SHL = 4'h7,
        FBCD_ALU_SHR = 4'h8,
        FBCD_ALU_PASS = 4'h0
    } fbcd_alu_e;
    typedef enum logic [3:0] {
        FBCD_AS_HL = 4'h0,
        FBCD_AS_DE = 4'h1,
        FBCD_AS_SP = 4'h2,
        FBCD_AS_PUSH = 4'h3
    } fbcd_asel_e;
    typedef struct packed {
        logic pc_load;
        logic pc_step;
        logic [6:0] page_in;
        logic [5:0] step_in;
        logic sp_load;
        logic [7:0] sp_in;
        logic sp_pop;
        logic mem_wr;
        logic mem_rd;
        fbcd_asel_e asel;
        logic [3:0] wdata;
        logic wdata_acc;
        fbcd_alu_e alu_op;
        logic alu_en;
        logic carry_set;
        logic carry_clr;
        logic acc_load;
        logic [3:0] acc_in;
        logic acc_from_mem;
        logic sub_load;
        logic pair_load;
        logic [7:0] pair_in;
        logic up_from_acc;
        logic idx_from_acc;
        logic acc_from_up;
        logic acc_from_idx;
        logic idx_inc;
        logic idx_dec;
        logic xchg_pairs;
    } fbcd_cmd_s;
    typedef struct packed {
        logic [6:0] page;
        logic [5:0] step;
        logic [7:0] rom_data;
        logic [3:0] acc;
        logic [3:0] sub;
        logic carry;
        logic [3:0] mem_data;
        logic up_eq;
        logic idx_eq;
        logic [3:0] io_sel;
    } fbcd_stat_s;
endpackage

// [verilog/fbcd_mem.sv]
// Dual-read memory: one port for the core, one for display refresh
`timescale 1ns/10ps
`include "fbcd_cfg.svh"
module fbcd_mem #(
    parameter int DW = 4,
    parameter int AW = 8
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata,
    input wire logic [AW-1:0] daddr,
    output logic [DW-1:0] ddata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
        ddata <= mem[daddr];
    end
endmodule // fbcd_mem

// [verilog/fbcd_core.sv]
// Datapath of the four-bit core: counters, stack, memory, ALU, pointers, display
`timescale 1ns/10ps
`include "fbcd_cfg.svh"
// Function
// RULE1: Program memory is 128 pages of 64 eight-bit steps, code and tables.
// RULE2: Program counter is a 7-bit page counter and 6-bit step counter.
// RULE3: Stack pointer is an 8-bit register holding the stack start address.
// RULE4: Reset leaves the stack pointer undefined until software loads it.
// RULE5: Stack pointer predecrements, so start 80 hex first uses 7F hex.
// RULE6: Data memory is 256 four-bit words on an 8-bit address.
// RULE7: Calls and interrupts save registers, counter and status on the stack.
// RULE8: Sixty-four display words are presented continuously to segment outputs.
// RULE9: Display addresses C0-FF; segment index is (hi-C)*16 plus low nibble.
// RULE10: Each segment shows its word bits in turn, one per common phase.
// RULE11: Display addresses read and write like any other data memory.
// RULE12: Working register takes results and sources memory and port transfers.
// RULE13: Second working register pairs with working register for 8-bit moves.
// RULE14: ALU adds, shifts, ANDs, ORs, XORs and complements with carry.
// RULE15: Upper and index pointer nibbles transfer and compare with working register.
// RULE16: Copy pair exchanges with pointer pair; either pair addresses memory.
// RULE17: Index nibble increments, decrements and selects the port or mode register.
// RULE18: Display refresh reads on its own port, never disturbing core accesses.
module fbcd_core #(
    parameter int PHASE_DIV = 1000,
    parameter logic [`FBCD_ROM_W-1:0] ROM_FILL = 8'h00
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire fbcd_pkg::fbcd_cmd_s cmd,
    input wire logic rom_we,
    input wire logic [12:0] rom_waddr,
    input wire logic [7:0] rom_wdata,
    output fbcd_pkg::fbcd_stat_s stat,
    output logic [63:0] segment_outputs,
    output logic [3:0] common_phase_outputs
);
    import fbcd_pkg::*;

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_a_ff, rst_b_ff;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_a_ff <= 1'b0;
            rst_b_ff <= 1'b0;
        end else begin
            rst_a_ff <= 1'b1;
            rst_b_ff <= rst_a_ff;
        end
    end
    wire rst_n = rst_b_ff;

    function automatic logic is_disp(input logic [7:0] a);
        is_disp = (a[7:6] == `FBCD_DISP_TOP_NIB);
    endfunction

    // ------------------------------------------------------------
    // Program memory and counter
    // ------------------------------------------------------------
    logic [6:0] page_counter_ff; // [RULE2]
    logic [5:0] step_counter_ff; // [RULE2]
    logic [7:0] rom_q;
    fbcd_mem #(.DW(`FBCD_ROM_W), .AW(`FBCD_PAGE_W + `FBCD_STEP_W)) u_rom (
        .clk(ref_clk),
        .we(rom_we),
        .waddr(rom_waddr), // [RULE1]
        .wdata(rom_wdata),
        .raddr({page_counter_ff, step_counter_ff}), // [RULE1] [RULE2]
        .rdata(rom_q),
        .daddr(13'h0000),
        .ddata()
    );
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            page_counter_ff <= 7'h00;
            step_counter_ff <= 6'h00;
        end else if (cmd.pc_load) begin
            page_counter_ff <= cmd.page_in; // [RULE2]
            step_counter_ff <= cmd.step_in;
        end else if (cmd.pc_step) begin
            step_counter_ff <= step_counter_ff + 6'h01; // [RULE2]
        end
    end

    // ------------------------------------------------------------
    // Stack pointer, no reset
    // ------------------------------------------------------------
    logic [7:0] stack_ptr_ff;
    logic push_q;
    always_comb push_q = cmd.mem_wr && (cmd.asel == FBCD_AS_PUSH);
    always_ff @(posedge ref_clk) begin
        if (cmd.sp_load) begin
            stack_ptr_ff <= cmd.sp_in; // [RULE3] [RULE4]
        end else if (push_q) begin
            stack_ptr_ff <= stack_ptr_ff - 8'h01; // [RULE5] [RULE7]
        end else if (cmd.sp_pop) begin
            stack_ptr_ff <= stack_ptr_ff + 8'h01; // [RULE7]
        end
    end

    // ------------------------------------------------------------
    // Registers and pointers
    // ------------------------------------------------------------
    logic [3:0] acc_ff, sub_ff, up_ff, idx_ff, cup_ff, clow_ff;
    logic carry_ff;
    logic [3:0] mem_q;

    // ------------------------------------------------------------
    // Arithmetic unit
    // ------------------------------------------------------------
    logic [3:0] alu_r;
    logic alu_c;
    always_comb begin
        alu_r = acc_ff;
        alu_c = carry_ff;
        unique case (cmd.alu_op)
            FBCD_ALU_ADD: {alu_c, alu_r} = {1'b0, acc_ff} + {1'b0, mem_q}; // [RULE14]
            FBCD_ALU_ADC: {alu_c, alu_r} = {1'b0, acc_ff} + {1'b0, mem_q} + {4'h0, carry_ff}; // [RULE14]
            FBCD_ALU_AND: alu_r = acc_ff & mem_q; // [RULE14]
            FBCD_ALU_OR: alu_r = acc_ff | mem_q; // [RULE14]
            FBCD_ALU_XOR: alu_r = acc_ff ^ mem_q; // [RULE14]
            FBCD_ALU_CPL: alu_r = ~acc_ff; // [RULE14]
            FBCD_ALU_SHL: {alu_c, alu_r} = {acc_ff, carry_ff}; // [RULE14]
            FBCD_ALU_SHR: {alu_r, alu_c} = {carry_ff, acc_ff}; // [RULE14]
            FBCD_ALU_PASS: alu_r = acc_ff;
            default: alu_r = acc_ff;
        endcase
    end

    // ------------------------------------------------------------
    // Accumulator and sub-accumulator
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_ff <= `FBCD_ZERO_NIB;
        end else begin
            if (cmd.alu_en) begin
                acc_ff <= alu_r; // [RULE12]
            end else if (cmd.pair_load) begin
                acc_ff <= cmd.pair_in[3:0]; // [RULE13]
            end else if (cmd.acc_from_mem) begin
                acc_ff <= mem_q;
            end else if (cmd.acc_from_up) begin
                acc_ff <= up_ff; // [RULE15]
            end else if (cmd.acc_from_idx) begin
                acc_ff <= idx_ff; // [RULE15]
            end else if (cmd.acc_load) begin
                acc_ff <= cmd.acc_in;
            end
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sub_ff <= `FBCD_ZERO_NIB;
        end else if (cmd.pair_load) begin
            sub_ff <= cmd.pair_in[7:4]; // [RULE13]
        end else if (cmd.sub_load) begin
            sub_ff <= acc_ff;
        end
    end

    // ------------------------------------------------------------
    // Carry flag, set beats clear beats result
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            carry_ff <= 1'b0;
        end else if (cmd.carry_set) begin
            carry_ff <= 1'b1; // [RULE14]
        end else if (cmd.carry_clr) begin
            carry_ff <= 1'b0; // [RULE14]
        end else if (cmd.alu_en) begin
            carry_ff <= alu_c; // [RULE14]
        end
    end

    // ------------------------------------------------------------
    // Pointer pairs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            up_ff <= `FBCD_ZERO_NIB;
            idx_ff <= `FBCD_ZERO_NIB;
            cup_ff <= `FBCD_ZERO_NIB;
            clow_ff <= `FBCD_ZERO_NIB;
        end else if (cmd.xchg_pairs) begin
            up_ff <= cup_ff; // [RULE16]
            idx_ff <= clow_ff;
            cup_ff <= up_ff;
            clow_ff <= idx_ff;
        end else begin
            if (cmd.up_from_acc) begin
                up_ff <= acc_ff; // [RULE15]
            end
            if (cmd.idx_from_acc) begin
                idx_ff <= acc_ff; // [RULE15]
            end else if (cmd.idx_inc) begin
                idx_ff <= idx_ff + 4'h1; // [RULE17]
            end else if (cmd.idx_dec) begin
                idx_ff <= idx_ff - 4'h1; // [RULE17]
            end
        end
    end

    // ------------------------------------------------------------
    // Data memory
    // ------------------------------------------------------------
    logic [7:0] addr;
    always_comb begin
        unique case (cmd.asel)
            FBCD_AS_HL: addr = {up_ff, idx_ff}; // [RULE16]
            FBCD_AS_DE: addr = {cup_ff, clow_ff}; // [RULE16]
            FBCD_AS_SP: addr = stack_ptr_ff;
            FBCD_AS_PUSH: addr = stack_ptr_ff - 8'h01; // [RULE5]
            default: addr = {up_ff, idx_ff};
        endcase
    end
    logic [5:0] scan_ff;
    logic [3:0] disp_q;
    logic [3:0] wd;
    always_comb wd = cmd.wdata_acc ? acc_ff : cmd.wdata; // [RULE12] [RULE7]
    fbcd_mem #(.DW(`FBCD_NIB_W), .AW(`FBCD_ADDR_W)) u_mem (
        .clk(ref_clk),
        .we(cmd.mem_wr),
        .waddr(addr), // [RULE6] [RULE11]
        .wdata(wd),
        .raddr(addr),
        .rdata(mem_q),
        .daddr(`FBCD_DISP_BASE | {2'b00, scan_ff}), // [RULE18] [RULE9]
        .ddata(disp_q)
    );

    // ------------------------------------------------------------
    // Display refresh
    // ------------------------------------------------------------
    logic [15:0] div_ff;
    logic [1:0] phase_ff;
    logic [63:0] shadow_ff [0:3];
    logic [5:0] cap_ff;
    logic cap_v_ff;
    wire tick = (div_ff == 16'(PHASE_DIV - 1));
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_ff <= 16'h0000;
            phase_ff <= 2'h0;
            scan_ff <= 6'h00;
            cap_ff <= 6'h00;
            cap_v_ff <= 1'b0;
        end else begin
            div_ff <= tick ? 16'h0000 : div_ff + 16'h0001;
            if (tick) begin
                phase_ff <= phase_ff + 2'h1; // [RULE10]
            end
            scan_ff <= scan_ff + 6'h01; // [RULE8]
            cap_ff <= scan_ff;
            cap_v_ff <= 1'b1;
        end
    end
    genvar gb;
    generate
        for (gb = 0; gb < `FBCD_PHASE_N; gb++) begin : g_bit
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    shadow_ff[gb] <= 64'h0;
                end else if (cap_v_ff) begin
                    shadow_ff[gb][cap_ff] <= disp_q[gb]; // [RULE9] [RULE10]
                end
            end
        end
    endgenerate
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            segment_outputs <= 64'h0;
            common_phase_outputs <= 4'h0;
        end else begin
            segment_outputs <= shadow_ff[phase_ff]; // [RULE8] [RULE10]
            common_phase_outputs <= 4'h1 << phase_ff; // [RULE10]
        end
    end

    // ------------------------------------------------------------
    // Status
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stat <= '0;
        end else begin
            stat.page <= page_counter_ff;
            stat.step <= step_counter_ff;
            stat.rom_data <= rom_q;
            stat.acc <= acc_ff; // [RULE12]
            stat.sub <= sub_ff; // [RULE13]
            stat.carry <= carry_ff;
            stat.mem_data <= mem_q;
            stat.up_eq <= (up_ff == acc_ff); // [RULE15]
            stat.idx_eq <= (idx_ff == acc_ff); // [RULE15]
            stat.io_sel <= idx_ff; // [RULE17]
        end
    end
    wire unused_ok = is_disp(addr) | rom_q[0];
endmodule // fbcd_core

// [sim/fbcd_core_chk.sv]
// Port checker of the four-bit core datapath
`timescale 1ns/10ps
module fbcd_core_chk #(
    parameter int PHASE_DIV = 1000
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire fbcd_pkg::fbcd_cmd_s cmd,
    input wire fbcd_pkg::fbcd_stat_s stat,
    input wire logic [3:0] common_phase_outputs
);
    import fbcd_pkg::*;
    logic [3:0] ph_q_ff;
    logic [1:0] seen_ff;
    logic [15:0] held_ff;
    logic moved;
    assign moved = common_phase_outputs != ph_q_ff;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ph_q_ff <= 4'h0;
            seen_ff <= 2'h0;
            held_ff <= 16'h0;
        end else begin
            ph_q_ff <= common_phase_outputs;
            held_ff <= moved ? 16'h0 : held_ff + 16'h1;
            if (moved && seen_ff != 2'h2) begin
                seen_ff <= seen_ff + 2'h1;
            end
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    chk_phase_onehot: assert property (seen_ff != 2'h0 |-> $onehot(common_phase_outputs))
        else $error("common phase not one-hot");
    chk_phase_order: assert property (seen_ff != 2'h0 && moved |->
        common_phase_outputs == {ph_q_ff[2:0], ph_q_ff[3]}) else $error("phase order wrong");
    chk_phase_hold: assert property (seen_ff == 2'h2 && moved |-> held_ff == PHASE_DIV - 1)
        else $error("phase length wrong");
    chk_pc_load: assert property (cmd.pc_load |-> ##2 stat.page == $past(cmd.page_in, 2) &&
        stat.step == $past(cmd.step_in, 2)) else $error("counter load wrong");
    chk_step_wrap: assert property (cmd.pc_step && !cmd.pc_load |-> ##2
        stat.step == $past(stat.step) + 6'h1 && $stable(stat.page)) else $error("step count wrong");
    chk_carry_set: assert property (cmd.carry_set && !cmd.alu_en |-> ##2 stat.carry)
        else $error("carry not set");
    chk_acc_load: assert property (cmd.acc_load && !(cmd.alu_en || cmd.pair_load || cmd.acc_from_mem ||
        cmd.acc_from_up || cmd.acc_from_idx) |-> ##2 stat.acc == $past(cmd.acc_in, 2)) else $error("acc load");
    chk_pair_load: assert property (cmd.pair_load && !cmd.alu_en && !cmd.sub_load |-> ##2
        {stat.sub, stat.acc} == $past(cmd.pair_in, 2)) else $error("pair load wrong");
    chk_index_inc: assert property (cmd.idx_inc && !(cmd.idx_dec || cmd.xchg_pairs || cmd.idx_from_acc)
        |-> ##2 stat.io_sel == $past(stat.io_sel) + 4'h1) else $error("index step wrong");
endmodule // fbcd_core_chk
bind fbcd_core fbcd_core_chk #(.PHASE_DIV(PHASE_DIV)) fbcd_core_chk_inst (.ref_clk(ref_clk), .rstn(rstn),
    .cmd(cmd), .stat(stat), .common_phase_outputs(common_phase_outputs));

// [sim/fbcd_lcd_model.sv]
// Segment driver model: last segment image seen in each phase
`timescale 1ns/10ps
module fbcd_lcd_model (
    input wire logic ref_clk,
    input wire logic [63:0] segment_outputs,
    input wire logic [3:0] common_phase_outputs
);
    logic [63:0] img [4];
    always @(posedge ref_clk) begin
        for (int p = 0; p < 4; p++) begin
            if (common_phase_outputs == (4'h1 << p)) begin
                img[p] <= segment_outputs;
            end
        end
    end
endmodule // fbcd_lcd_model

// [sim/tb_four_bit_core_datapath.sv]
// Testbench of the four-bit core datapath
`timescale 1ns/10ps
module tb_four_bit_core_datapath;
    import fbcd_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    fbcd_cmd_s cmd = '0;
    fbcd_cmd_s c;
    logic rom_we = 1'b0;
    logic [12:0] rom_waddr = 13'h0;
    logic [7:0] rom_wdata = 8'h0;
    fbcd_stat_s stat;
    logic [63:0] segment_outputs;
    logic [3:0] common_phase_outputs;
    int num_errors = 0;
    int checked = 0;
    fbcd_core #(.PHASE_DIV(4)) fbcd_core_inst (.ref_clk(ref_clk), .rstn(rstn), .cmd(cmd), .rom_we(rom_we),
        .rom_waddr(rom_waddr), .rom_wdata(rom_wdata), .stat(stat), .segment_outputs(segment_outputs),
        .common_phase_outputs(common_phase_outputs));
    fbcd_lcd_model fbcd_lcd_model_inst (.ref_clk(ref_clk), .segment_outputs(segment_outputs),
        .common_phase_outputs(common_phase_outputs));
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic finish_test;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] want);
        checked++;
        if (got !== want) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic drive(input fbcd_cmd_s v, input int n);
        @(posedge ref_clk);
        cmd <= v;
        repeat (n) @(posedge ref_clk);
        cmd <= '0;
    endtask
    task automatic ld_acc(input logic [3:0] v, input logic up, input logic idx);
        c = '0;
        c.acc_load = 1'b1;
        c.acc_in = v;
        drive(c, 1);
        c = '0;
        c.up_from_acc = up;
        c.idx_from_acc = idx;
        drive(c, 1);
    endtask
    task automatic set_hl(input logic [7:0] a);
        ld_acc(a[7:4], 1'b1, 1'b0);
        ld_acc(a[3:0], 1'b0, 1'b1);
    endtask
    task automatic wr(input fbcd_asel_e s, input logic [3:0] v);
        c = '0;
        c.mem_wr = 1'b1;
        c.asel = s;
        c.wdata = v;
        drive(c, 1);
    endtask
    task automatic rd(input fbcd_asel_e s, input fbcd_alu_e op);
        c = '0;
        c.mem_rd = 1'b1;
        c.asel = s;
        @(posedge ref_clk);
        cmd <= c;
        repeat (3) @(posedge ref_clk);
        c.alu_op = op;
        c.alu_en = (op != FBCD_ALU_PASS);
        c.acc_from_mem = 1'b1;
        cmd <= c;
        @(posedge ref_clk);
        cmd <= '0;
        wait_n(2);
    endtask
    task automatic t_rom_pc;
        @(posedge ref_clk);
        rom_we <= 1'b1;
        rom_waddr <= 13'h1fff;
        rom_wdata <= 8'ha5;
        @(posedge ref_clk);
        rom_waddr <= 13'h1fc0;
        rom_wdata <= 8'h3c;
        @(posedge ref_clk);
        rom_we <= 1'b0;
        c = '0;
        c.pc_load = 1'b1;
        c.page_in = 7'h7f;
        c.step_in = 6'h3f;
        drive(c, 1);
        wait_n(3);
        chk(stat.rom_data, 8'ha5);
        c = '0;
        c.pc_step = 1'b1;
        drive(c, 1);
        wait_n(3);
        chk({1'b0, stat.page}, 8'h7f);
        chk({2'h0, stat.step}, 8'h00);
        chk(stat.rom_data, 8'h3c);
    endtask
    task automatic t_stack;
        c = '0;
        c.sp_load = 1'b1;
        c.sp_in = 8'h80;
        drive(c, 1);
        wr(FBCD_AS_PUSH, 4'h9);
        wr(FBCD_AS_PUSH, 4'h4);
        set_hl(8'h7f);
        rd(FBCD_AS_HL, FBCD_ALU_PASS);
        chk(stat.acc, 8'h9);
        set_hl(8'h7e);
        rd(FBCD_AS_HL, FBCD_ALU_PASS);
        chk(stat.acc, 8'h4);
        chk(stat.mem_data, 8'h4);
        ld_acc(4'hc, 1'b0, 1'b0);
        c = '0;
        c.mem_wr = 1'b1;
        c.asel = FBCD_AS_PUSH;
        c.wdata_acc = 1'b1;
        drive(c, 1);
        c = '0;
        c.sp_pop = 1'b1;
        drive(c, 2);
        rd(FBCD_AS_SP, FBCD_ALU_PASS);
        chk(stat.acc, 8'h9);
        set_hl(8'h7d);
        rd(FBCD_AS_HL, FBCD_ALU_PASS);
        chk(stat.acc, 8'hc);
    endtask
    task automatic t_alu;
        fbcd_alu_e ops [8] = '{FBCD_ALU_ADD, FBCD_ALU_ADC, FBCD_ALU_AND, FBCD_ALU_OR, FBCD_ALU_XOR,
            FBCD_ALU_CPL, FBCD_ALU_SHL, FBCD_ALU_SHR};
        logic [3:0] res [8] = '{4'h1, 4'h2, 4'h2, 4'hf, 4'hd, 4'h4, 4'h6, 4'h5};
        set_hl(8'h20);
        wr(FBCD_AS_HL, 4'h6);
        for (int i = 0; i < 8; i++) begin
            ld_acc(4'hb, 1'b0, 1'b0);
            c = '0;
            c.carry_set = (i == 1);
            c.carry_clr = (i != 1);
            drive(c, 1);
            rd(FBCD_AS_HL, ops[i]);
            chk(stat.acc, res[i]);
            if (i < 2) begin
                chk(stat.carry, 8'h1);
            end
        end
    endtask
    task automatic t_ptr;
        set_hl(8'h3c);
        wr(FBCD_AS_HL, 4'h7);
        c = '0;
        c.xchg_pairs = 1'b1;
        drive(c, 1);
        set_hl(8'h12);
        wait_n(2);
        chk({stat.io_sel, 3'h0, stat.idx_eq}, 8'h21);
        rd(FBCD_AS_DE, FBCD_ALU_PASS);
        chk(stat.acc, 8'h7);
        c = '0;
        c.acc_from_up = 1'b1;
        drive(c, 1);
        wait_n(2);
        chk({stat.acc, 3'h0, stat.up_eq}, 8'h11);
        c = '0;
        c.idx_dec = 1'b1;
        drive(c, 2);
        c = '0;
        c.idx_inc = 1'b1;
        drive(c, 3);
        wait_n(2);
        chk(stat.io_sel, 8'h3);
        c = '0;
        c.pair_load = 1'b1;
        c.pair_in = 8'h6a;
        drive(c, 1);
        wait_n(2);
        chk({stat.sub, stat.acc}, 8'h6a);
        c = '0;
        c.acc_from_idx = 1'b1;
        c.sub_load = 1'b1;
        drive(c, 1);
        wait_n(2);
        chk({stat.sub, stat.acc}, 8'ha3);
    endtask
    task automatic t_disp;
        logic [5:0] idx [3] = '{6'd0, 6'd21, 6'd63};
        logic [3:0] val [3] = '{4'h5, 4'ha, 4'h3};
        for (int i = 0; i < 3; i++) begin
            set_hl({2'h3, idx[i]});
            wr(FBCD_AS_HL, val[i]);
        end
        wait_n(300);
        for (int i = 0; i < 3; i++) begin
            for (int p = 0; p < 4; p++) begin
                chk(fbcd_lcd_model_inst.img[p][idx[i]], val[i][p]);
            end
            set_hl({2'h3, idx[i]});
            rd(FBCD_AS_HL, FBCD_ALU_PASS);
            chk(stat.acc, val[i]);
        end
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        t_rom_pc;
        t_stack;
        t_alu;
        t_ptr;
        t_disp;
        finish_test;
    end
    initial begin
        #100us;
        num_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        finish_test;
    end
endmodule // tb_four_bit_core_datapath
